// ===== common/tce_pkg.sv
// Shared constants, register map and carrier types of the capture, event and square-wave timer.
package tce_pkg;

  localparam int          DATA_W          = 32;
  localparam int          CNT_W           = 16;
  localparam int          OFF_W           = 8;

  localparam logic [7:0]  OFF_MODE        = 8'h00;
  localparam logic [7:0]  OFF_CRC         = 8'h04;
  localparam logic [7:0]  OFF_TOC         = 8'h08;
  localparam logic [7:0]  OFF_PRM         = 8'h0c;
  localparam logic [7:0]  OFF_COUNT       = 8'h10;
  localparam logic [7:0]  OFF_CCA         = 8'h14;
  localparam logic [7:0]  OFF_CAPB        = 8'h18;
  localparam logic [7:0]  OFF_STAT        = 8'h1c;

  localparam int          MODE_OP_LO      = 2;
  localparam int          CRC_A_CAPTURE   = 0;
  localparam int          CRC_A_INVERSE   = 1;
  localparam logic [7:0]  CRC_WR_MASK     = 8'h07;
  localparam int          TOC_OUT_EN      = 0;
  localparam int          TOC_MATCH_TGL   = 1;
  localparam int          PRM_CLK_LO      = 0;
  localparam int          PRM_ES_LO       = 4;
  localparam int          STAT_OVF        = 0;
  localparam int          STAT_PIN        = 1;

  localparam logic [7:0]  MODE_RST        = 8'h00;
  localparam logic [7:0]  CRC_RST         = 8'h00;
  localparam logic [7:0]  TOC_RST         = 8'h00;
  localparam logic [7:0]  PRM_RST         = 8'h00;
  localparam logic [15:0] CCA_RST         = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES    = 16'hffff;

  localparam logic [1:0]  CLK_FX          = 2'h0;
  localparam logic [1:0]  CLK_FX_DIV_A    = 2'h1;
  localparam logic [1:0]  CLK_FX_DIV_B    = 2'h2;
  localparam logic [1:0]  CLK_EXT         = 2'h3;
  localparam int          DIV_A           = 4;
  localparam int          DIV_B           = 256;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {OP_STOP, OP_RESTART, OP_FREE, OP_MATCH} tce_op_type;
  typedef enum logic [1:0] {ES_FALL, ES_RISE, ES_NONE, ES_BOTH} tce_edge_type;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] crc;
    logic [7:0] toc;
    logic [7:0] prm;
  } tce_cfg_type;

  localparam tce_cfg_type CFG_RST = '{mode: MODE_RST, crc: CRC_RST, toc: TOC_RST, prm: PRM_RST};

endpackage

// ===== rtl/tce_pin_filter.sv
// Input pin synchroniser and two-sample noise filter.
module tce_pin_filter (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  input  wire logic sample_en,
  output logic      level
);
  logic s1_q, s2_q, s3_q, stab_q, last_q, level_q;
  logic stab_d, last_d, level_d;

  // The stable level moves only when the second and third stages agree.
  always_comb begin
    stab_d  = (s2_q == s3_q) ? s3_q : stab_q;
    last_d  = sample_en ? stab_q : last_q;
    level_d = (sample_en && stab_q == last_q) ? stab_q : level_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      stab_q  <= 1'b0;
      last_q  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      stab_q  <= stab_d;
      last_q  <= last_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule

// ===== rtl/tce_prescale.sv
// Count clock enable generator: internal clock, two divided rates or the input pin edge.
module tce_prescale #(
  parameter int DIV_A_P = 4,
  parameter int DIV_B_P = 256
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  input  wire logic       ext_edge,
  output logic            tick
);
  import tce_pkg::*;
  localparam int W = $clog2(DIV_B_P) + 1;
  localparam logic [W-1:0] LAST_A = W'(DIV_A_P - 1);
  localparam logic [W-1:0] LAST_B = W'(DIV_B_P - 1);
  logic [W-1:0] div_q, div_d;
  logic         wrap;

  always_comb begin
    wrap  = (sel == CLK_FX_DIV_A) ? (div_q == LAST_A) : (div_q == LAST_B);
    div_d = (!run || wrap) ? '0 : div_q + W'(1);
    case (sel)
      CLK_FX:       tick = run;
      CLK_FX_DIV_A: tick = run && wrap;
      CLK_FX_DIV_B: tick = run && wrap;
      default:      tick = run && ext_edge;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end
endmodule

// ===== rtl/tce_top.sv
// Timer slice: pulse width capture, external event counting and square-wave output.
// How it works
// R01 - Free-running: selected input edge copies count into capture B, pulses request B.
// R02 - Free-running: opposite edge copies count into compare/capture A when enabled.
// R03 - Measurement: input sampled at count clock, edge accepted after two equal samples.
// R04 - Restart mode: valid edge captures count into B, then clears counter.
// R05 - Restart mode: rising or falling edge chosen by the edge-select field.
// R06 - Software clears the overflow flag; hardware never clears it itself.
// R07 - Event counter: count register increments once per valid input edge.
// R08 - Event counter: count equal to A clears count and pulses request A.
// R09 - Software loads compare A nonzero in event counter mode.
// R10 - Event counter: rising, falling or both edges are selectable.
// R11 - Event counter: input sampled with internal clock, two equal samples needed.
// R12 - Event counter: overflow set only when A is all ones and passed.
// R13 - Software reads the count register for the current event count.
// R14 - Software sets capture control, clock, nonzero compare, then mode to start.
// R15 - Capture control bit 0 clear makes A a compare; bits 7 to 3 zero.
// R16 - Square wave: both output bits set invert the pin each A plus one counts.
// R17 - Software leaves compare A alone while the square wave runs.
// R18 - Software sets clock, capture control, output control, compare, then mode.
// R19 - Two low prescaler bits select the count clock source.
// R20 - Counting starts once the operation mode bits leave the stop code.
// R21 - Free-running count wraps from all ones to zero and sets overflow.
module tce_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  timer_input_pin,
  output logic                       timer_output_pin,
  output logic                       timer_output_oe,
  output logic                       irq_match_a,
  output logic                       irq_capture_b
);
  import tce_pkg::*;

  tce_cfg_type          cfg_q, cfg_d;
  logic [ADDR_W-1:0]    awaddr_q, awaddr_d;
  logic                 aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0]          wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]           wstrb_q, wstrb_d;
  logic                 bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]           bresp_q, bresp_d, rresp_q, rresp_d;
  logic                 do_write, wr_cca, ovf_clr;
  logic [31:0]          wr_val;
  logic [CNT_W-1:0]     cnt_q, cnt_d, cca_q, cca_d, capb_q, capb_d;
  logic                 ovf_q, ovf_d, out_q, out_d, prev_q, prev_d;
  logic                 irq_a_q, irq_a_d, irq_b_q, irq_b_d;
  tce_op_type           op;
  tce_edge_type         es;
  logic                 run, tick, sample_en, level, rise, fall;
  logic                 sel_edge, inv_edge, cap_b_ev, cap_a_ev, match_ev;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction
  // The map is dense up to the status word, so an aligned offset beyond it is unmapped.
  function automatic logic known(input logic [7:0] off);
    return off <= OFF_STAT;
  endfunction

  assign op  = tce_op_type'(cfg_q.mode[MODE_OP_LO +: 2]);
  assign es  = tce_edge_type'(cfg_q.prm[PRM_ES_LO +: 2]);
  assign run = (op != OP_STOP); // R20

  // Event counting samples at the internal clock; measurement samples at the count clock.
  assign sample_en = (cfg_q.prm[PRM_CLK_LO +: 2] == CLK_EXT) ? run : tick; // R03 R11

  tce_pin_filter u_filter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin       (timer_input_pin),
    .sample_en (sample_en),
    .level     (level)
  );

  tce_prescale #(
    .DIV_A_P (DIV_A),
    .DIV_B_P (DIV_B)
  ) u_prescale (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (run),
    .sel      (cfg_q.prm[PRM_CLK_LO +: 2]), // R19
    .ext_edge (sel_edge),
    .tick     (tick)
  );

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign do_write      = aw_have_q && w_have_q;

  // Address and data may arrive in either order; the write lands once both are held.
  always_comb begin
    logic [7:0] woff, roff;
    woff      = 8'(awaddr_q) & 8'hfc;
    roff      = 8'(s_axi_araddr) & 8'hfc;
    cfg_d     = cfg_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    bvalid_d  = bvalid_q && !s_axi_bready;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q && !s_axi_rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wr_cca    = 1'b0;
    ovf_clr   = 1'b0;
    wr_val    = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_d  = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
      w_have_d = 1'b1;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = known(woff) ? RESP_OKAY : RESP_SLVERR;
      case (woff)
        OFF_MODE: begin
          wr_val     = merge({24'h0, cfg_q.mode}, wdata_q, wstrb_q);
          cfg_d.mode = wr_val[7:0];
        end
        OFF_CRC: begin
          wr_val    = merge({24'h0, cfg_q.crc}, wdata_q, wstrb_q);
          cfg_d.crc = wr_val[7:0] & CRC_WR_MASK; // R15
        end
        OFF_TOC: begin
          wr_val    = merge({24'h0, cfg_q.toc}, wdata_q, wstrb_q);
          cfg_d.toc = wr_val[7:0];
        end
        OFF_PRM: begin
          wr_val    = merge({24'h0, cfg_q.prm}, wdata_q, wstrb_q);
          cfg_d.prm = wr_val[7:0];
        end
        OFF_CCA: begin
          wr_val = merge({16'h0, cca_q}, wdata_q, wstrb_q);
          wr_cca = 1'b1;
        end
        OFF_STAT: ovf_clr = wstrb_q[0] && wdata_q[STAT_OVF]; // R06
        default:  wr_val = 32'h0000_0000;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = known(roff) ? RESP_OKAY : RESP_SLVERR;
      case (roff)
        OFF_MODE:  rdata_d = {24'h0, cfg_q.mode};
        OFF_CRC:   rdata_d = {24'h0, cfg_q.crc};
        OFF_TOC:   rdata_d = {24'h0, cfg_q.toc};
        OFF_PRM:   rdata_d = {24'h0, cfg_q.prm};
        OFF_COUNT: rdata_d = {16'h0, cnt_q}; // R13
        OFF_CCA:   rdata_d = {16'h0, cca_q};
        OFF_CAPB:  rdata_d = {16'h0, capb_q};
        OFF_STAT:  rdata_d = {30'h0, level, ovf_q};
        default:   rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= CFG_RST;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      cfg_q     <= cfg_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // A stopped timer ignores the pin, so edges seen only while running count.
  always_comb begin
    rise = run && level && !prev_q;
    fall = run && !level && prev_q;
    case (es) // R05 R10
      ES_FALL: {sel_edge, inv_edge} = {fall, rise};
      ES_RISE: {sel_edge, inv_edge} = {rise, fall};
      ES_BOTH: {sel_edge, inv_edge} = {rise || fall, 1'b0};
      default: {sel_edge, inv_edge} = 2'h0;
    endcase
    cap_b_ev = (op == OP_FREE || op == OP_RESTART) && sel_edge; // R01 R04
    cap_a_ev = (op == OP_FREE) && cfg_q.crc[CRC_A_CAPTURE] &&
               cfg_q.crc[CRC_A_INVERSE] && inv_edge; // R02
    match_ev = (op == OP_MATCH) && tick && !cfg_q.crc[CRC_A_CAPTURE] &&
               (cnt_q == cca_q); // R08 R15
  end

  always_comb begin
    cnt_d   = cnt_q;
    cca_d   = wr_cca ? wr_val[15:0] : cca_q;
    capb_d  = capb_q;
    ovf_d   = ovf_q && !ovf_clr;
    out_d   = out_q;
    prev_d  = run ? level : prev_q;
    irq_a_d = 1'b0;
    irq_b_d = cap_b_ev; // R01
    case (op)
      OP_STOP: cnt_d = '0;
      OP_FREE, OP_RESTART: begin
        if (tick) begin
          cnt_d = cnt_q + 16'h0001; // R21
          if (cnt_q == CNT_ALL_ONES) begin
            ovf_d = 1'b1; // R21
          end
        end
        if (op == OP_RESTART && cap_b_ev) begin
          cnt_d = '0; // R04
        end
      end
      default: begin
        if (match_ev) begin
          cnt_d   = '0; // R08
          irq_a_d = 1'b1; // R08
          if (cca_q == CNT_ALL_ONES) begin
            ovf_d = 1'b1; // R12
          end
          if (cfg_q.toc[TOC_OUT_EN] && cfg_q.toc[TOC_MATCH_TGL]) begin
            out_d = !out_q; // R16
          end
        end else if (tick) begin
          cnt_d = cnt_q + 16'h0001; // R07
        end
      end
    endcase
    // A capture beats a simultaneous software write to the same register.
    if (cap_b_ev) begin
      capb_d = cnt_q; // R01 R04
    end
    if (cap_a_ev) begin
      cca_d   = cnt_q; // R02
      irq_a_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= '0;
      cca_q   <= CCA_RST;
      capb_q  <= '0;
      ovf_q   <= 1'b0;
      out_q   <= 1'b0;
      prev_q  <= 1'b0;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      cca_q   <= cca_d;
      capb_q  <= capb_d;
      ovf_q   <= ovf_d;
      out_q   <= out_d;
      prev_q  <= prev_d;
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
    end
  end
  assign timer_output_pin = out_q;
  assign timer_output_oe  = cfg_q.toc[TOC_OUT_EN];
  assign irq_match_a      = irq_a_q;
  assign irq_capture_b    = irq_b_q;

  a_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    (op == OP_STOP) |=> (cnt_q == '0)) else $error("stopped counter not zero");
  a_wrap_ovf: assert property (@(posedge aclk) disable iff (!aresetn) // R21
    (op == OP_FREE && tick && cnt_q == CNT_ALL_ONES) |=> (ovf_q && cnt_q == '0))
    else $error("free-running wrap lost overflow");
  a_capb_value: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    cap_b_ev |=> (capb_q == $past(cnt_q) && irq_capture_b))
    else $error("capture B wrong value or no request");
  a_capa_value: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    cap_a_ev |=> (cca_q == $past(cnt_q))) else $error("capture A wrong value");
  a_restart_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    (op == OP_RESTART && cap_b_ev) |=> (cnt_q == '0)) else $error("restart did not clear");
  a_match_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R08
    match_ev |=> (cnt_q == '0 && irq_match_a)) else $error("match did not clear");
  a_event_inc: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    (op == OP_MATCH && tick && !match_ev) |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("event count not incremented");
  a_match_ovf: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    (op == OP_MATCH && !ovf_q && !cap_a_ev && !(match_ev && cca_q == CNT_ALL_ONES))
    |=> !ovf_q) else $error("overflow set without all-ones compare");
  a_wave_toggle: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    (match_ev && cfg_q.toc[TOC_OUT_EN] && cfg_q.toc[TOC_MATCH_TGL])
    |=> (timer_output_pin != $past(timer_output_pin))) else $error("square wave missed toggle");
  a_ovf_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    (ovf_q && !ovf_clr) |=> ovf_q) else $error("overflow cleared by hardware");
  a_filter_edge: assert property (@(posedge aclk) disable iff (!aresetn) // R03 R11
    (rise || fall) |-> $past(sample_en)) else $error("edge without sampling");
endmodule

// ===== testbench/tce_pin_model.sv
// Far-side model: pulse source on the timer input and a load that times the timer output.
module tce_pin_model (
  input  wire logic aclk,
  input  wire logic out_pin,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int   gap_q;
  int   run_q;
  logic out_q;

  initial begin
    pin = 1'b0;
    gap_q = 0;
    run_q = 0;
    out_q = 1'b0;
  end

  // Levels change just after an edge and last whole cycles, so filter delays stay repeatable.
  task automatic pulse(input int hi, input int lo);
    @(posedge aclk);
    pin <= 1'b1;
    repeat (hi) @(posedge aclk);
    pin <= 1'b0;
    repeat (lo) @(posedge aclk);
  endtask

  // Records the number of cycles between the last two inversions of the output.
  always @(posedge aclk) begin
    out_q <= out_pin;
    if (out_pin !== out_q) begin
      gap_q <= run_q;
      run_q <= 1;
    end else begin
      run_q <= run_q + 1;
    end
  end
endmodule

// ===== testbench/tce_top_test.sv
// Self-checking bench for the timer slice, driven over its register bus and input pin.
module tce_top_test;
  import tce_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin;
  logic awready, wready, bvalid, arready, rvalid, out_pin, out_oe, irq_a, irq_b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, e;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          errors, cmp_count, n_a, n_b, na, nb;
  logic [7:0]  offs [8] = '{OFF_MODE, OFF_CRC, OFF_TOC, OFF_PRM, OFF_COUNT, OFF_CCA, OFF_CAPB,
                            OFF_STAT};
  logic [7:0]  sel [2] = '{8'h10, 8'h00};

  tce_top tce_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_input_pin(pin), .timer_output_pin(out_pin),
    .timer_output_oe(out_oe), .irq_match_a(irq_a), .irq_capture_b(irq_b));
  tce_pin_model tce_pin_model_inst (.aclk(aclk), .out_pin(out_pin), .pin(pin));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (irq_a === 1'b1) n_a++;
    if (irq_b === 1'b1) n_b++;
  end

  task automatic summarize();
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic rng(input string n, input int lo, input int hi, input logic [31:0] g);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  // Address and data are offered together; each is dropped only at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    bit aw_ok, w_ok, aw_hs, w_hs, b;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      @(posedge aclk);
      if (aw_hs) begin
        awvalid <= 1'b0;
        aw_ok = 1;
      end
      if (w_hs) begin
        wvalid <= 1'b0;
        w_ok = 1;
      end
    end
    do begin
      @(negedge aclk);
      b = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!b);
    bready <= 1'b0;
    @(posedge aclk);
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a);
    bit hs, v;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = arready;
      @(posedge aclk);
    end while (!hs);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!v);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic setup(input logic [7:0] m, c, t, p, input logic [15:0] a);
    wr(OFF_MODE, 32'h0, RESP_OKAY);
    if (t != 8'h00) wr(OFF_PRM, {24'h0, p}, RESP_OKAY);
    wr(OFF_CRC, {24'h0, c}, RESP_OKAY);
    if (t == 8'h00) wr(OFF_PRM, {24'h0, p}, RESP_OKAY);
    wr(OFF_TOC, {24'h0, t}, RESP_OKAY);
    wr(OFF_CCA, {16'h0, a}, RESP_OKAY);
    wr(OFF_MODE, {24'h0, m}, RESP_OKAY);
  endtask

  initial begin
    repeat (95000) @(posedge aclk);
    errors++;
    summarize();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (offs[i]) begin
      rd(offs[i]);
      check("reset value", 32'h0, d);
    end
    rd(8'h20);
    check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(OFF_CRC, 32'hff, RESP_OKAY);
    rd(OFF_CRC);
    check("crc mask", {24'h0, CRC_WR_MASK}, d);
    // Event counting, compare at three.
    setup(8'h0c, 8'h00, 8'h00, 8'h13, 16'd3);
    repeat (3) tce_pin_model_inst.pulse(12, 12);
    rd(OFF_COUNT);
    check("event count", 32'd3, d);
    na = n_a;
    tce_pin_model_inst.pulse(12, 12);
    rd(OFF_COUNT);
    check("count after match", 32'd0, d);
    check("match irq", na + 1, n_a);
    tce_pin_model_inst.pulse(1, 12);
    rd(OFF_COUNT);
    check("glitch count", 32'd0, d);
    setup(8'h0c, 8'h00, 8'h00, 8'h33, 16'd9);
    tce_pin_model_inst.pulse(12, 12);
    rd(OFF_COUNT);
    check("both edges", 32'd2, d);
    setup(8'h0c, 8'h00, 8'h00, 8'h03, 16'd9);
    tce_pin_model_inst.pulse(12, 12);
    rd(OFF_COUNT);
    check("falling edge", 32'd1, d);
    setup(8'h0c, 8'h00, 8'h00, 8'h23, 16'd9);
    tce_pin_model_inst.pulse(12, 12);
    rd(OFF_COUNT);
    check("no edge selected", 32'd0, d);
    // Free-running with both capture registers.
    setup(8'h08, 8'h03, 8'h00, 8'h10, 16'h0);
    nb = n_b;
    tce_pin_model_inst.pulse(100, 20);
    rd(OFF_CAPB);
    e = d;
    rd(OFF_CCA);
    rng("pulse width", 99, 101, d - e);
    check("capture irq", nb + 1, n_b);
    // Restart on rising, then falling edge.
    foreach (sel[i]) begin
      setup(8'h04, 8'h00, 8'h00, sel[i], 16'h0);
      tce_pin_model_inst.pulse(50, 150);
      tce_pin_model_inst.pulse(50, 150);
      rd(OFF_CAPB);
      rng("restart capture", 199, 201, d);
      rd(OFF_COUNT);
      rng("restart count", (i == 0) ? 185 : 135, (i == 0) ? 200 : 150, d);
    end
    // Square wave at every cycle and at both divided rates.
    for (int k = 0; k < 3; k++) begin
      setup(8'h0c, 8'h00, 8'h03, k[7:0], 16'd9);
      repeat ((k == 2) ? 5300 : 150) @(posedge aclk);
      e = 32'(10 * ((k == 0) ? 1 : (k == 1) ? DIV_A : DIV_B));
      check("toggle gap", e, tce_pin_model_inst.gap_q);
      check("output enable", 32'h1, {31'h0, out_oe});
    end
    // Free-running wrap; the flag stays until written back.
    setup(8'h08, 8'h00, 8'h00, 8'h00, 16'h0);
    rd(OFF_COUNT);
    rng("started count", 1, 30, d);
    repeat (65550) @(posedge aclk);
    rd(OFF_STAT);
    check("overflow set", 32'h1, {31'h0, d[STAT_OVF]});
    wr(OFF_STAT, 32'h1, RESP_OKAY);
    rd(OFF_STAT);
    check("overflow clear", 32'h0, {31'h0, d[STAT_OVF]});
    summarize();
  end
endmodule
